// file: logic/rfil_pkg.sv
// Constants for the rail fault interrupt logic: register map, flag layout, reset values.
// Assumes a 32-bit register port and a single 20 MHz device clock.
package rfil_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int unsigned NPH    = 4;
	localparam int unsigned NMON   = 2;
	localparam int unsigned NGRP   = 4;
	localparam int unsigned NTRIG  = 3;
	localparam int unsigned NF     = 20;
	localparam int unsigned NRAW   = 28;
	localparam int unsigned AW     = 8;
	localparam int unsigned DW     = 32;
	localparam int unsigned GW     = 2;
	localparam int unsigned SYNC_N = 2;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [AW-1:0] ADDR_FLAG  = 8'h00;
	localparam logic [AW-1:0] ADDR_MASK  = 8'h04;
	localparam logic [AW-1:0] ADDR_LIVE  = 8'h08;
	localparam logic [AW-1:0] ADDR_RESEN = 8'h0c;
	localparam logic [AW-1:0] ADDR_GRP   = 8'h10;
	localparam logic [AW-1:0] ADDR_TRIG  = 8'h14;

	// ----------------------------------------------------------------
	// Flag vector layout (same layout in FLAG, MASK and LIVE)
	// ----------------------------------------------------------------
	localparam int unsigned SC_LSB  = 0;
	localparam int unsigned POV_LSB = 4;
	localparam int unsigned PUV_LSB = 8;
	localparam int unsigned SOV_BIT = 12;
	localparam int unsigned SUV_BIT = 13;
	localparam int unsigned MOV_LSB = 14;
	localparam int unsigned MUV_LSB = 16;
	localparam int unsigned MRV_LSB = 18;
	// Raw input vector: flag sources, then phase residual, then low-after-ramp
	localparam int unsigned PRV_LSB = 20;
	localparam int unsigned LOW_LSB = 24;

	// Only the over/undervoltage sources carry a mask and a live bit
	localparam logic [NF-1:0] MASKABLE = 20'h3fff0;

	// Group-select layout: phases, then analog supply, then monitors
	localparam int unsigned GRP_SUP_LSB = 8;
	localparam int unsigned GRP_MON_LSB = 10;
	localparam int unsigned GRP_W       = 14;
	localparam int unsigned TRIG_W      = 8;
	localparam int unsigned RESEN_W     = 6;
	localparam int unsigned RESEN_MON   = 4;

	// Trigger code that requests no sequencer transition
	localparam logic [GW-1:0] TRIG_NONE = 2'h3;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [NF-1:0]      RST_FLAG  = 20'h00000;
	localparam logic [NF-1:0]      RST_MASK  = 20'h00000;
	localparam logic [RESEN_W-1:0] RST_RESEN = 6'h00;
	localparam logic [GRP_W-1:0]   RST_GRP   = 14'h0000;
	localparam logic [TRIG_W-1:0]  RST_TRIG  = 8'hff;
	localparam logic [DW-1:0]      RD_ZERO   = 32'h00000000;

endpackage : rfil_pkg

// file: logic/rfil_top.sv
// Rail fault interrupt logic: converter phase, analog supply and monitor input
// faults set sticky flags, request sequencer triggers and drive an active-low interrupt.
// Assumes fault comparator outputs arrive asynchronously; enable, power-up and the
// register port are on i_sys_clk.
//
// Our own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps

module rfil_top (
	input  wire logic                        i_sys_clk,
	input  wire logic                        i_rst,
	input  wire logic                        i_clk_en,
	// Fault comparators (asynchronous)
	input  wire logic [rfil_pkg::NPH-1:0]    i_phase_short,
	input  wire logic [rfil_pkg::NPH-1:0]    i_phase_residual,
	input  wire logic [rfil_pkg::NPH-1:0]    i_phase_low_after_ramp,
	input  wire logic [rfil_pkg::NPH-1:0]    i_phase_overvolt,
	input  wire logic [rfil_pkg::NPH-1:0]    i_phase_undervolt,
	input  wire logic                        i_supply_overvolt,
	input  wire logic                        i_supply_undervolt,
	input  wire logic [rfil_pkg::NMON-1:0]   i_monitor_overvolt,
	input  wire logic [rfil_pkg::NMON-1:0]   i_monitor_undervolt,
	input  wire logic [rfil_pkg::NMON-1:0]   i_monitor_residual,
	// Device state on the same clock
	input  wire logic [rfil_pkg::NPH-1:0]    i_phase_enabled,
	input  wire logic                        i_powerup_done,
	// Register port
	input  wire logic [rfil_pkg::AW-1:0]     i_addr,
	input  wire logic [rfil_pkg::DW-1:0]     i_wr_data,
	input  wire logic                        i_wr_en,
	input  wire logic                        i_rd_en,
	output logic      [rfil_pkg::DW-1:0]     o_rd_data,
	// Results
	output logic [rfil_pkg::NPH-1:0]         o_phase_disable,
	output logic [rfil_pkg::NTRIG-1:0]       o_seq_trigger,
	output logic                             o_interrupt_out_n
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	logic [rfil_pkg::NRAW-1:0] raw;
	logic [rfil_pkg::NRAW-1:0] meta_q;
	logic [rfil_pkg::NRAW-1:0] sync_q;
	logic [rfil_pkg::NRAW-1:0] prev_q;
	logic [rfil_pkg::NRAW-1:0] meta_d;
	logic [rfil_pkg::NRAW-1:0] sync_d;
	logic [rfil_pkg::NRAW-1:0] prev_d;

	assign raw = {i_phase_low_after_ramp, i_phase_residual, i_monitor_residual,
		i_monitor_undervolt, i_monitor_overvolt, i_supply_undervolt, i_supply_overvolt,
		i_phase_undervolt, i_phase_overvolt, i_phase_short};

	always_comb begin
		meta_d = meta_q;
		sync_d = sync_q;
		prev_d = prev_q;
		if (i_clk_en) begin
			meta_d = raw;
			sync_d = meta_q;
			prev_d = sync_q;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			meta_q <= '0;
			sync_q <= '0;
			prev_q <= '0;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [rfil_pkg::NF-1:0]      mask_q;
	logic [rfil_pkg::NF-1:0]      mask_d;
	logic [rfil_pkg::RESEN_W-1:0] resen_q;
	logic [rfil_pkg::RESEN_W-1:0] resen_d;
	logic [rfil_pkg::GRP_W-1:0]   grp_q;
	logic [rfil_pkg::GRP_W-1:0]   grp_d;
	logic [rfil_pkg::TRIG_W-1:0]  trig_q;
	logic [rfil_pkg::TRIG_W-1:0]  trig_d;
	logic                         wr_flag;

	always_comb begin
		mask_d  = mask_q;
		resen_d = resen_q;
		grp_d   = grp_q;
		trig_d  = trig_q;
		if (i_clk_en && i_wr_en) begin
			if (i_addr == rfil_pkg::ADDR_MASK) begin
				mask_d = i_wr_data[rfil_pkg::NF-1:0] & rfil_pkg::MASKABLE;
			end else if (i_addr == rfil_pkg::ADDR_RESEN) begin
				resen_d = i_wr_data[rfil_pkg::RESEN_W-1:0];
			end else if (i_addr == rfil_pkg::ADDR_GRP) begin
				grp_d = i_wr_data[rfil_pkg::GRP_W-1:0];
			end else if (i_addr == rfil_pkg::ADDR_TRIG) begin
				trig_d = i_wr_data[rfil_pkg::TRIG_W-1:0];
			end
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			mask_q  <= rfil_pkg::RST_MASK;
			resen_q <= rfil_pkg::RST_RESEN;
			grp_q   <= rfil_pkg::RST_GRP;
			trig_q  <= rfil_pkg::RST_TRIG;
		end else begin
			mask_q  <= mask_d;
			resen_q <= resen_d;
			grp_q   <= grp_d;
			trig_q  <= trig_d;
		end
	end

	assign wr_flag = i_clk_en && i_wr_en && (i_addr == rfil_pkg::ADDR_FLAG);

	// ----------------------------------------------------------------
	// Fault events
	// ----------------------------------------------------------------
	logic [rfil_pkg::NF-1:0]   cond;
	logic [rfil_pkg::NF-1:0]   rise;
	logic [rfil_pkg::NF-1:0]   event_v;
	logic [rfil_pkg::NF-1:0]   refuse;
	logic [rfil_pkg::NPH-1:0]  prv_rise;
	logic [rfil_pkg::NPH-1:0]  prv_event;
	logic [rfil_pkg::NPH-1:0]  prv_live;
	logic [rfil_pkg::NPH-1:0]  low_live;
	logic [rfil_pkg::NMON-1:0] mon_resen;

	assign cond      = sync_q[rfil_pkg::NF-1:0];
	assign rise      = sync_q[rfil_pkg::NF-1:0] & ~prev_q[rfil_pkg::NF-1:0];
	assign prv_live  = sync_q[rfil_pkg::PRV_LSB +: rfil_pkg::NPH];
	assign prv_rise  = prv_live & ~prev_q[rfil_pkg::PRV_LSB +: rfil_pkg::NPH];
	assign low_live  = sync_q[rfil_pkg::LOW_LSB +: rfil_pkg::NPH];
	assign mon_resen = resen_q[rfil_pkg::RESEN_MON +: rfil_pkg::NMON];
	assign prv_event = prv_rise & resen_q[rfil_pkg::NPH-1:0];

	always_comb begin
		event_v = rise;
		event_v[rfil_pkg::SC_LSB +: rfil_pkg::NPH] =
			rise[rfil_pkg::SC_LSB +: rfil_pkg::NPH] | prv_event;
		event_v[rfil_pkg::MRV_LSB +: rfil_pkg::NMON] =
			rise[rfil_pkg::MRV_LSB +: rfil_pkg::NMON] & mon_resen;
		// Over/undervoltage clears wait for the fault to end
		refuse = cond & rfil_pkg::MASKABLE;
		refuse[rfil_pkg::SC_LSB +: rfil_pkg::NPH] = i_phase_enabled & low_live;
		refuse[rfil_pkg::MRV_LSB +: rfil_pkg::NMON] = '0;
	end

	// ----------------------------------------------------------------
	// Sticky flags
	// ----------------------------------------------------------------
	logic [rfil_pkg::NF-1:0]  flag_q;
	logic [rfil_pkg::NF-1:0]  flag_d;
	logic [rfil_pkg::NPH-1:0] hide_q;
	logic [rfil_pkg::NPH-1:0] hide_d;

	genvar gi;
	generate
		for (gi = 0; gi < rfil_pkg::NF; gi++) begin : g_flag
			logic set_bit;
			logic clr_bit;
			assign set_bit = event_v[gi] & ~mask_q[gi];
			assign clr_bit = wr_flag & i_wr_data[gi] & ~refuse[gi];
			// A set in the clearing cycle wins, so no event is lost
			assign flag_d[gi] = i_clk_en ? (set_bit | (flag_q[gi] & ~clr_bit)) : flag_q[gi];
		end
		for (gi = 0; gi < rfil_pkg::NPH; gi++) begin : g_hide
			logic hide_set;
			logic hide_end;
			assign hide_set = prv_event[gi];
			// Released by a completed power-up with the residual gone, or as soon as the flag clears
			assign hide_end = (i_powerup_done & ~prv_live[gi]) | ~flag_d[gi];
			assign hide_d[gi] = i_clk_en ? (hide_set | (hide_q[gi] & ~hide_end)) : hide_q[gi];
		end
	endgenerate

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			flag_q <= rfil_pkg::RST_FLAG;
			hide_q <= '0;
		end else begin
			flag_q <= flag_d;
			hide_q <= hide_d;
		end
	end

	// ----------------------------------------------------------------
	// Sequencer triggers and phase disable
	// ----------------------------------------------------------------
	logic [rfil_pkg::GW-1:0]    src_grp [rfil_pkg::NF];
	logic [rfil_pkg::NTRIG-1:0] trig_req;
	logic [rfil_pkg::GW-1:0]    code;

	always_comb begin
		for (int i = 0; i < rfil_pkg::NPH; i++) begin
			src_grp[rfil_pkg::SC_LSB + i]  = grp_q[i*rfil_pkg::GW +: rfil_pkg::GW];
			src_grp[rfil_pkg::POV_LSB + i] = grp_q[i*rfil_pkg::GW +: rfil_pkg::GW];
			src_grp[rfil_pkg::PUV_LSB + i] = grp_q[i*rfil_pkg::GW +: rfil_pkg::GW];
		end
		src_grp[rfil_pkg::SOV_BIT] = grp_q[rfil_pkg::GRP_SUP_LSB +: rfil_pkg::GW];
		src_grp[rfil_pkg::SUV_BIT] = grp_q[rfil_pkg::GRP_SUP_LSB +: rfil_pkg::GW];
		for (int m = 0; m < rfil_pkg::NMON; m++) begin
			src_grp[rfil_pkg::MOV_LSB + m] =
				grp_q[rfil_pkg::GRP_MON_LSB + m*rfil_pkg::GW +: rfil_pkg::GW];
			src_grp[rfil_pkg::MUV_LSB + m] =
				grp_q[rfil_pkg::GRP_MON_LSB + m*rfil_pkg::GW +: rfil_pkg::GW];
			src_grp[rfil_pkg::MRV_LSB + m] =
				grp_q[rfil_pkg::GRP_MON_LSB + m*rfil_pkg::GW +: rfil_pkg::GW];
		end
		// Trigger ignores the interrupt mask: masking only silences the host
		trig_req = '0;
		code     = rfil_pkg::TRIG_NONE;
		for (int i = 0; i < rfil_pkg::NF; i++) begin
			code = trig_q[src_grp[i]*rfil_pkg::GW +: rfil_pkg::GW];
			if (event_v[i] && code != rfil_pkg::TRIG_NONE) begin
				trig_req[code] = 1'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// Outputs and read port
	// ----------------------------------------------------------------
	logic [rfil_pkg::DW-1:0]    rd_data_q;
	logic [rfil_pkg::DW-1:0]    rd_data_d;
	logic [rfil_pkg::NPH-1:0]   disable_q;
	logic [rfil_pkg::NPH-1:0]   disable_d;
	logic [rfil_pkg::NTRIG-1:0] trigger_q;
	logic [rfil_pkg::NTRIG-1:0] trigger_d;
	logic                       irq_n_q;
	logic                       irq_n_d;
	logic [rfil_pkg::NF-1:0]    flag_view;

	always_comb begin
		flag_view = flag_q;
		flag_view[rfil_pkg::SC_LSB +: rfil_pkg::NPH] =
			flag_q[rfil_pkg::SC_LSB +: rfil_pkg::NPH] & ~hide_q;
		rd_data_d = rfil_pkg::RD_ZERO;
		if (i_rd_en) begin
			if (i_addr == rfil_pkg::ADDR_FLAG) begin
				rd_data_d[rfil_pkg::NF-1:0] = flag_view;
			end else if (i_addr == rfil_pkg::ADDR_MASK) begin
				rd_data_d[rfil_pkg::NF-1:0] = mask_q;
			end else if (i_addr == rfil_pkg::ADDR_LIVE) begin
				rd_data_d[rfil_pkg::NF-1:0] = cond & rfil_pkg::MASKABLE;
			end else if (i_addr == rfil_pkg::ADDR_RESEN) begin
				rd_data_d[rfil_pkg::RESEN_W-1:0] = resen_q;
			end else if (i_addr == rfil_pkg::ADDR_GRP) begin
				rd_data_d[rfil_pkg::GRP_W-1:0] = grp_q;
			end else if (i_addr == rfil_pkg::ADDR_TRIG) begin
				rd_data_d[rfil_pkg::TRIG_W-1:0] = trig_q;
			end
		end
		// Disable is a one-cycle request; re-enabling is the sequencer's choice
		disable_d = event_v[rfil_pkg::SC_LSB +: rfil_pkg::NPH];
		trigger_d = trig_req;
		irq_n_d   = ~|(flag_q & ~mask_q);
		if (!i_clk_en) begin
			rd_data_d = rd_data_q;
			disable_d = disable_q;
			trigger_d = trigger_q;
			irq_n_d   = irq_n_q;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			rd_data_q <= rfil_pkg::RD_ZERO;
			disable_q <= '0;
			trigger_q <= '0;
			irq_n_q   <= 1'h1;
		end else begin
			rd_data_q <= rd_data_d;
			disable_q <= disable_d;
			trigger_q <= trigger_d;
			irq_n_q   <= irq_n_d;
		end
	end

	assign o_rd_data         = rd_data_q;
	assign o_phase_disable   = disable_q;
	assign o_seq_trigger     = trigger_q;
	assign o_interrupt_out_n = irq_n_q;

endmodule : rfil_top

// file: test/rfil_top_properties.sv
// Concurrent properties on the ports of the rail fault interrupt logic.
// Assumes i_clk_en is held high by the bench; bound to rfil_top below.
`timescale 1ns/1ps

module rfil_props (
	input  wire logic                     i_sys_clk,
	input  wire logic                     i_rst,
	input  wire logic [rfil_pkg::NPH-1:0] i_phase_short,
	input  wire logic [rfil_pkg::NPH-1:0] i_phase_residual,
	input  wire logic [rfil_pkg::AW-1:0]  i_addr,
	input  wire logic                     i_wr_en,
	input  wire logic                     i_rd_en,
	input  wire logic [rfil_pkg::DW-1:0]  o_rd_data,
	input  wire logic [rfil_pkg::NPH-1:0] o_phase_disable,
	input  wire logic                     o_interrupt_out_n
);
	// Either fault kind may disable a phase
	logic [rfil_pkg::NPH-1:0] cause;
	assign cause = i_phase_short | i_phase_residual;

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);

	short_disable_a: assert property ($rose(i_phase_short[0]) |-> ##[3:5] o_phase_disable[0])
		else $error("phase 0 short gave no disable pulse");
	short_pin_a: assert property ($rose(i_phase_short[1]) |-> ##[3:6] !o_interrupt_out_n)
		else $error("phase 1 short did not pull the interrupt low");
	disable_cause_a: assert property (o_phase_disable[2] |->
		$past(cause[2], 3) || $past(cause[2], 4))
		else $error("phase 2 disabled without a fault");
	disable_pulse_a: assert property (o_phase_disable[3] |=> !o_phase_disable[3])
		else $error("phase 3 disable longer than one cycle");
	pin_hold_a: assert property (!o_interrupt_out_n && !i_wr_en && !$past(i_wr_en)
		|=> !o_interrupt_out_n)
		else $error("interrupt released without a host write");
	rd_idle_a: assert property (!$past(i_rd_en) |-> o_rd_data == rfil_pkg::RD_ZERO)
		else $error("read data not zero outside a read");
	live_bits_a: assert property ($past(i_rd_en) && $past(i_addr) == rfil_pkg::ADDR_LIVE
		|-> (o_rd_data & ~{12'h000, rfil_pkg::MASKABLE}) == rfil_pkg::RD_ZERO)
		else $error("live bit outside over/undervoltage sources");
	mask_bits_a: assert property ($past(i_rd_en) && $past(i_addr) == rfil_pkg::ADDR_MASK
		|-> (o_rd_data & ~{12'h000, rfil_pkg::MASKABLE}) == rfil_pkg::RD_ZERO)
		else $error("mask bit outside over/undervoltage sources");
	unmapped_zero_a: assert property ($past(i_rd_en) && $past(i_addr) > rfil_pkg::ADDR_TRIG
		|-> o_rd_data == rfil_pkg::RD_ZERO)
		else $error("unmapped read not zero");
endmodule : rfil_props

bind rfil_top rfil_props u_props (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
	.i_phase_short(i_phase_short), .i_phase_residual(i_phase_residual), .i_addr(i_addr),
	.i_wr_en(i_wr_en), .i_rd_en(i_rd_en), .o_rd_data(o_rd_data),
	.o_phase_disable(o_phase_disable), .o_interrupt_out_n(o_interrupt_out_n));

// file: test/rfil_host.sv
// Host processor model: reads, masks and clears flags over the register port.
// Assumes the bench calls its tasks from one process.
`timescale 1ns/1ps

module rfil_host (
	input  wire logic        i_sys_clk,
	input  wire logic [31:0] i_rd_data,
	output logic      [7:0]  o_addr,
	output logic      [31:0] o_wr_data,
	output logic             o_wr_en,
	output logic             o_rd_en
);
	// Idle cycles before each request, so the host can be prompt or slow
	int slow = 0;

	initial begin
		o_addr = 8'h00;
		o_wr_data = 32'h00000000;
		o_wr_en = 1'h0;
		o_rd_en = 1'h0;
	end

	// Writing one clears a flag; the device may refuse it
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		repeat (slow) @(posedge i_sys_clk);
		@(posedge i_sys_clk);
		o_addr <= a;
		o_wr_data <= d;
		o_wr_en <= 1'h1;
		@(posedge i_sys_clk);
		o_wr_en <= 1'h0;
		o_wr_data <= ~d;
		o_addr <= ~a;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		repeat (slow) @(posedge i_sys_clk);
		@(posedge i_sys_clk);
		o_addr <= a;
		o_rd_en <= 1'h1;
		@(posedge i_sys_clk);
		o_rd_en <= 1'h0;
		o_addr <= ~a;
		@(posedge i_sys_clk);
		d = i_rd_data;
	endtask : rd
endmodule : rfil_host

// file: test/rfil_top_test.sv
// Self-checking bench for the rail fault interrupt logic.
// Assumes a 20 MHz clock; fault levels drive a vector laid out like the flag register.
`timescale 1ns/1ps

module rfil_top_test;
	logic        i_sys_clk = 1'h0;
	logic        i_rst     = 1'h1;
	logic [19:0] src       = 20'h00000;
	logic [3:0]  pres      = 4'h0;
	logic [3:0]  plow      = 4'h0;
	logic [3:0]  pen       = 4'h0;
	logic        pup       = 1'h0;
	logic [7:0]  addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic        wr;
	logic        rd;
	logic [3:0]  dis;
	logic [2:0]  trig;
	logic        irq_n;
	logic [3:0]  dseen     = 4'h0;
	logic [2:0]  tseen     = 3'h0;
	logic        seen_clr  = 1'h0;
	logic [15:0] rnd       = 16'h005c;
	logic [13:0] grp;
	logic [7:0]  trg;
	int          n_errors  = 0;
	int          checked   = 0;
	int          b;
	int          p;

	always #25 i_sys_clk = ~i_sys_clk;

	rfil_host host (.i_sys_clk(i_sys_clk), .i_rd_data(rdata), .o_addr(addr), .o_wr_data(wdata),
		.o_wr_en(wr), .o_rd_en(rd));

	rfil_top dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_clk_en(1'h1),
		.i_phase_short(src[3:0]), .i_phase_residual(pres), .i_phase_low_after_ramp(plow),
		.i_phase_overvolt(src[7:4]), .i_phase_undervolt(src[11:8]),
		.i_supply_overvolt(src[12]), .i_supply_undervolt(src[13]),
		.i_monitor_overvolt(src[15:14]), .i_monitor_undervolt(src[17:16]),
		.i_monitor_residual(src[19:18]), .i_phase_enabled(pen), .i_powerup_done(pup),
		.i_addr(addr), .i_wr_data(wdata), .i_wr_en(wr), .i_rd_en(rd), .o_rd_data(rdata),
		.o_phase_disable(dis), .o_seq_trigger(trig), .o_interrupt_out_n(irq_n));

	// Pulses are one cycle long, so they are gathered rather than sampled
	always @(posedge i_sys_clk) begin
		dseen <= seen_clr ? 4'h0 : (dseen | dis);
		tseen <= seen_clr ? 3'h0 : (tseen | trig);
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : lfsr

	function automatic logic [2:0] exp_trig(input int k);
		int          s;
		logic [1:0]  g;
		logic [1:0]  c;
		s = (k < 12) ? 2 * (k % 4) : (k < 14) ? 8 : 10 + 2 * ((k - 14) % 2);
		g = grp[s+:2];
		c = trg[2*g+:2];
		return (c == 2'h3) ? 3'h0 : 3'h1 << c;
	endfunction : exp_trig

	task automatic close_out;
		$display("checked %0d, n_errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : close_out

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask : chk

	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
		logic [31:0] v;
		host.rd(a, v);
		chk(nm, e, v);
	endtask : rdchk

	task automatic settle;
		repeat (6) @(posedge i_sys_clk);
	endtask : settle

	// Gathering has one owner: the clear is a request taken at the next edge
	task automatic clr_seen;
		seen_clr <= 1'h1;
		@(posedge i_sys_clk);
		seen_clr <= 1'h0;
	endtask : clr_seen

	task automatic wait_pin(input logic lvl);
		for (int k = 0; k < 8 && irq_n !== lvl; k++) @(posedge i_sys_clk);
		chk("interrupt pin", {31'h0, lvl}, {31'h0, irq_n});
		if (irq_n !== lvl) close_out();
	endtask : wait_pin

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge i_sys_clk);
		i_rst <= 1'h0;
		host.wr(8'h18, 32'hffffffff);
		rdchk(rfil_pkg::ADDR_FLAG, 32'h0, "flag reset");
		rdchk(rfil_pkg::ADDR_MASK, 32'h0, "mask reset");
		rdchk(rfil_pkg::ADDR_LIVE, 32'h0, "live reset");
		rdchk(rfil_pkg::ADDR_RESEN, 32'h0, "residual enable reset");
		rdchk(rfil_pkg::ADDR_GRP, 32'h0, "group reset");
		rdchk(rfil_pkg::ADDR_TRIG, 32'hff, "trigger reset");
		rdchk(8'h18, 32'h0, "unmapped");
		wait_pin(1'h1);
		rnd = lfsr(rnd);
		grp = rnd[13:0];
		host.slow = int'(rnd[15:14]);
		rnd = lfsr(rnd);
		trg = rnd[7:0];
		host.wr(rfil_pkg::ADDR_GRP, {18'h0, grp});
		host.wr(rfil_pkg::ADDR_TRIG, {24'h0, trg});
		host.wr(rfil_pkg::ADDR_RESEN, 32'h30);
		rdchk(rfil_pkg::ADDR_GRP, {18'h0, grp}, "group");
		rdchk(rfil_pkg::ADDR_TRIG, {24'h0, trg}, "trigger select");
		for (b = 0; b < 20; b++) begin
			clr_seen();
			@(posedge i_sys_clk) src[b] <= 1'h1;
			settle();
			rdchk(rfil_pkg::ADDR_FLAG, 32'h1 << b, "flag on event");
			if (rfil_pkg::MASKABLE[b]) rdchk(rfil_pkg::ADDR_LIVE, 32'h1 << b, "live");
			chk("trigger", {29'h0, exp_trig(b)}, {29'h0, tseen});
			chk("disable", (b < 4) ? 32'h1 << b : 32'h0, {28'h0, dseen});
			wait_pin(1'h0);
			host.wr(rfil_pkg::ADDR_FLAG, 32'h1 << b);
			rdchk(rfil_pkg::ADDR_FLAG, rfil_pkg::MASKABLE[b] ? 32'h1 << b : 32'h0, "held");
			@(posedge i_sys_clk) src[b] <= 1'h0;
			settle();
			host.wr(rfil_pkg::ADDR_FLAG, 32'h1 << b);
			rdchk(rfil_pkg::ADDR_FLAG, 32'h0, "cleared");
			wait_pin(1'h1);
		end
		rnd = lfsr(rnd);
		p = int'(rnd[1:0]);
		@(posedge i_sys_clk) src[p] <= 1'h1;
		pen[p] <= 1'h1;
		plow[p] <= 1'h1;
		settle();
		host.wr(rfil_pkg::ADDR_FLAG, 32'h1 << p);
		rdchk(rfil_pkg::ADDR_FLAG, 32'h1 << p, "short clear refused");
		@(posedge i_sys_clk) plow[p] <= 1'h0;
		settle();
		host.wr(rfil_pkg::ADDR_FLAG, 32'h1 << p);
		rdchk(rfil_pkg::ADDR_FLAG, 32'h0, "short clear taken");
		@(posedge i_sys_clk) src[p] <= 1'h0;
		pen[p] <= 1'h0;
		host.wr(rfil_pkg::ADDR_MASK, 32'hffffffff);
		rdchk(rfil_pkg::ADDR_MASK, {12'h0, rfil_pkg::MASKABLE}, "mask layout");
		rnd = lfsr(rnd);
		b = 4 + int'(rnd % 16'h000e);
		host.wr(rfil_pkg::ADDR_MASK, 32'h1 << b);
		clr_seen();
		@(posedge i_sys_clk) src[b] <= 1'h1;
		settle();
		rdchk(rfil_pkg::ADDR_FLAG, 32'h0, "masked event");
		chk("masked trigger", {29'h0, exp_trig(b)}, {29'h0, tseen});
		wait_pin(1'h1);
		@(posedge i_sys_clk) src[b] <= 1'h0;
		host.wr(rfil_pkg::ADDR_MASK, 32'h0);
		@(posedge i_sys_clk) src[b] <= 1'h1;
		settle();
		wait_pin(1'h0);
		host.wr(rfil_pkg::ADDR_MASK, 32'h1 << b);
		wait_pin(1'h1);
		rdchk(rfil_pkg::ADDR_FLAG, 32'h1 << b, "kept under mask");
		@(posedge i_sys_clk) src[b] <= 1'h0;
		settle();
		host.wr(rfil_pkg::ADDR_FLAG, 32'h1 << b);
		rdchk(rfil_pkg::ADDR_FLAG, 32'h0, "cleared under mask");
		host.wr(rfil_pkg::ADDR_MASK, 32'h0);
		rnd = lfsr(rnd);
		p = int'(rnd[3:2]);
		clr_seen();
		@(posedge i_sys_clk) pres[p] <= 1'h1;
		settle();
		chk("residual off", 32'h0, {28'h0, dseen});
		rdchk(rfil_pkg::ADDR_FLAG, 32'h0, "residual off flag");
		@(posedge i_sys_clk) pres[p] <= 1'h0;
		host.wr(rfil_pkg::ADDR_RESEN, 32'h30 | (32'h1 << p));
		clr_seen();
		@(posedge i_sys_clk) pres[p] <= 1'h1;
		settle();
		chk("residual disable", 32'h1 << p, {28'h0, dseen});
		chk("residual trigger", {29'h0, exp_trig(p)}, {29'h0, tseen});
		rdchk(rfil_pkg::ADDR_FLAG, 32'h0, "hidden flag");
		wait_pin(1'h0);
		@(posedge i_sys_clk) pres[p] <= 1'h0;
		settle();
		rdchk(rfil_pkg::ADDR_FLAG, 32'h0, "hidden before power-up");
		@(posedge i_sys_clk) pup <= 1'h1;
		@(posedge i_sys_clk) pup <= 1'h0;
		rdchk(rfil_pkg::ADDR_FLAG, 32'h1 << p, "shown after power-up");
		host.wr(rfil_pkg::ADDR_FLAG, 32'h1 << p);
		wait_pin(1'h1);
		close_out();
	end
endmodule : rfil_top_test
